// ---- pdc_decode.sv ----
// Power-down decode: turns pin level and control bits into the enables.
// Assumes a synchronised pin level and registers its outputs.
`timescale 1ns/100ps
`default_nettype none
module pdc_decode
  import pdc_pkg::*;
(
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  input wire logic pin_level_in,
  input wire logic [31:0] ctrl_in,
  output logic dig_pd_out,
  output logic pll_pd_out,
  output logic dac_pd_out,
  output logic clk_pd_out,
  output logic [1:0] mode_out
);

  pdc_mode_t mode_d;

  // ==========================================================================
  // Mode selection
  // ==========================================================================
  // Pin low means software control; pin high picks depth from the select bit.
  always_comb
  begin
    if (!pin_level_in)
      mode_d = PDC_MODE_SW;
    else if (ctrl_in[PDC_BIT_FULL])
      mode_d = PDC_MODE_FULL;
    else
      mode_d = PDC_MODE_FAST;
  end

  // Outputs are 1 for low power, 0 for active.
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      dig_pd_out <= 1'b0;
      pll_pd_out <= 1'b0;
      dac_pd_out <= 1'b0;
      clk_pd_out <= 1'b0;
      mode_out <= 2'h0;
    end
    else if (clk_en_in)
    begin
      pll_pd_out <= ctrl_in[PDC_BIT_PLL];
      mode_out <= 2'(mode_d);
      unique case (mode_d)
        PDC_MODE_SW:
        begin
          dig_pd_out <= ctrl_in[PDC_BIT_DIG];
          dac_pd_out <= ctrl_in[PDC_BIT_DAC];
          clk_pd_out <= ctrl_in[PDC_BIT_CLK];
        end
        PDC_MODE_FAST:
        begin
          dig_pd_out <= 1'b1;
          dac_pd_out <= 1'b0;
          clk_pd_out <= 1'b0;
        end
        PDC_MODE_FULL:
        begin
          dig_pd_out <= 1'b1;
          dac_pd_out <= 1'b1;
          clk_pd_out <= 1'b1;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ---- pdc_host_pin.sv ----
// Host model that drives the external power-down pin of the block.
// Assumes the bench asks for a pin level on the same clock.
`timescale 1ns/100ps
`default_nettype none
module pdc_host_pin
(
  input wire logic clock_in,
  input wire logic level_in,
  input wire logic slow_in,
  output var logic pin_out
);
  // ==========================================================================
  // Pin driver
  // ==========================================================================
  logic [2:0] dly_q = 3'h0;
  // A slow host lags three cycles; the pin moves off the edge, since the
  // real pin is not tied to this clock.
  always @(posedge clock_in)
  begin
    dly_q <= {dly_q[1:0], level_in};
    pin_out <= #1 (slow_in ? dly_q[2] : level_in);
  end
endmodule
`default_nettype wire

// ---- pdc_pkg.sv ----
// Package for the power-down control block: register map, bit positions
// and reset values.
// Assumes an AXI4-Lite slave with 32-bit data and word-aligned registers.
package pdc_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [7:0] PDC_CTRL_ONE_OFFS = 8'h00;
  localparam logic [7:0] PDC_STATUS_OFFS = 8'h04;
  localparam logic [31:0] PDC_CTRL_ONE_RST = 32'h0000_0000;

  // ==========================================================================
  // Bit positions in control_function_reg_one
  // ==========================================================================
  localparam int PDC_BIT_DIG = 7;
  localparam int PDC_BIT_PLL = 6;
  localparam int PDC_BIT_DAC = 5;
  localparam int PDC_BIT_CLK = 4;
  localparam int PDC_BIT_FULL = 3;

  // ==========================================================================
  // Bus answers
  // ==========================================================================
  localparam logic [1:0] PDC_RESP_OKAY = 2'h0;
  localparam logic [1:0] PDC_RESP_SLVERR = 2'h2;

  typedef enum {PDC_MODE_SW, PDC_MODE_FAST, PDC_MODE_FULL} pdc_mode_t;

endpackage

// ---- pdc_top.sv ----
// Power-down control top: AXI4-Lite registers, pin synchroniser, decode.
// Assumes one 250 MHz clock and an asynchronous power-down pin.
//
// What this block does
// - Four software power-down bits in control bits 7:4.
// - Pin high masks software bits except bit 6.
// - Pin high enters power-down, depth from bit 3.
// - Pin low: software bits alone decide.
// - Pin high, bit 3 clear: only digital down.
// - Pin high, bit 3 set: all three down.
// - Every power-down signal is active high.
// - Software mode: digital=7, converter=5, clock=4.
//
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module pdc_top
  import pdc_pkg::*;
(
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  input wire logic external_powerdown_pin_in,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic dig_pd_out,
  output logic pll_pd_out,
  output logic dac_pd_out,
  output logic clk_pd_out
);

  logic pin_meta_q;
  logic pin_sync_q;
  logic [31:0] control_function_reg_one_q;
  logic aw_held_q;
  logic w_held_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic [1:0] mode_w;
  logic do_write;

  // Byte-lane merge, used by the register write.
  function automatic logic [31:0] pdc_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        res[i*8 +: 8] = new_v[i*8 +: 8];
    return res;
  endfunction

  // Word decode of the control register, shared by write, answer and read.
  function automatic logic pdc_is_ctrl(input logic [7:0] addr);
    return addr[7:2] == PDC_CTRL_ONE_OFFS[7:2];
  endfunction

  // ==========================================================================
  // Pin synchroniser
  // ==========================================================================
  // Two flops: the pin is driven by the host with no clock relation.
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
    end
    else if (clk_en_in)
    begin
      pin_meta_q <= external_powerdown_pin_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  // ==========================================================================
  // Write channel
  // ==========================================================================
  // Address and data are captured separately in either order.
  assign do_write = aw_held_q && w_held_q && !s_axi_bvalid_out;

  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out <= 1'b0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= PDC_RESP_OKAY;
    end
    else if (clk_en_in)
    begin
      s_axi_awready_out <= !aw_held_q && !s_axi_awready_out;
      s_axi_wready_out <= !w_held_q && !s_axi_wready_out;
      if (s_axi_awvalid_in && s_axi_awready_out)
      begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr_in;
        s_axi_awready_out <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out)
      begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata_in;
        w_strb_q <= s_axi_wstrb_in;
        s_axi_wready_out <= 1'b0;
      end
      if (do_write)
      begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= pdc_is_ctrl(aw_addr_q) ? PDC_RESP_OKAY :
                                                    PDC_RESP_SLVERR;
      end
      else if (s_axi_bvalid_out && s_axi_bready_in)
        s_axi_bvalid_out <= 1'b0;
    end
  end

  // Control register: bits 7:3 steer the decode, the rest are storage.
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
      control_function_reg_one_q <= PDC_CTRL_ONE_RST;
    else if (clk_en_in && do_write && pdc_is_ctrl(aw_addr_q))
      control_function_reg_one_q <= pdc_merge(control_function_reg_one_q,
                                              w_data_q, w_strb_q);
  end

  // ==========================================================================
  // Read channel
  // ==========================================================================
  // Status word: bit 0 synced pin, bits 2:1 mode, bits 7:4 live enables.
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0000_0000;
      s_axi_rresp_out <= PDC_RESP_OKAY;
    end
    else if (clk_en_in)
    begin
      s_axi_arready_out <= !s_axi_rvalid_out && !s_axi_arready_out;
      if (s_axi_arvalid_in && s_axi_arready_out)
      begin
        s_axi_arready_out <= 1'b0;
        s_axi_rvalid_out <= 1'b1;
        s_axi_rresp_out <= PDC_RESP_OKAY;
        if (pdc_is_ctrl(s_axi_araddr_in))
          s_axi_rdata_out <= control_function_reg_one_q;
        else if (s_axi_araddr_in[7:2] == PDC_STATUS_OFFS[7:2])
          s_axi_rdata_out <= {24'h00_0000, dig_pd_out, pll_pd_out,
                              dac_pd_out, clk_pd_out, 1'b0, mode_w,
                              pin_sync_q};
        else
        begin
          s_axi_rdata_out <= 32'h0000_0000;
          s_axi_rresp_out <= PDC_RESP_SLVERR;
        end
      end
      else if (s_axi_rvalid_out && s_axi_rready_in)
        s_axi_rvalid_out <= 1'b0;
    end
  end

  // ==========================================================================
  // Power-down decode
  // ==========================================================================
  // Only bit 6 bypasses the pin; the others are masked in the decode.
  pdc_decode u_decode (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .clk_en_in(clk_en_in),
    .pin_level_in(pin_sync_q),
    .ctrl_in(control_function_reg_one_q),
    .dig_pd_out(dig_pd_out),
    .pll_pd_out(pll_pd_out),
    .dac_pd_out(dac_pd_out),
    .clk_pd_out(clk_pd_out),
    .mode_out(mode_w)
  );

  // ==========================================================================
  // Checks
  // ==========================================================================
  // The decode updates on the enabled edge itself, so the next edge must
  // show the result whatever the enable does there.
  fast_mode_a: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    clk_en_in && pin_sync_q && !control_function_reg_one_q[PDC_BIT_FULL]
    |=> dig_pd_out && !dac_pd_out && !clk_pd_out)
    else $error("Fast recovery outputs wrong.");

  full_mode_a: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    clk_en_in && pin_sync_q && control_function_reg_one_q[PDC_BIT_FULL]
    |=> dig_pd_out && dac_pd_out && clk_pd_out)
    else $error("Full power-down outputs wrong.");

  soft_mode_a: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    clk_en_in && !pin_sync_q |=>
    {dig_pd_out, dac_pd_out, clk_pd_out} ==
    $past({control_function_reg_one_q[PDC_BIT_DIG],
           control_function_reg_one_q[PDC_BIT_DAC],
           control_function_reg_one_q[PDC_BIT_CLK]}))
    else $error("Software outputs do not follow bits.");

  pll_follow_a: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    clk_en_in |=>
    pll_pd_out == $past(control_function_reg_one_q[PDC_BIT_PLL]))
    else $error("PLL power-down does not follow bit 6.");

  pin_mask_a: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    clk_en_in && pin_sync_q |=> dig_pd_out)
    else $error("Pin high did not override digital bit.");

  pin_depth_a: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    clk_en_in && pin_sync_q |=> mode_w != 2'h0)
    else $error("Pin high did not enter power-down.");

  pin_off_a: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    clk_en_in && !pin_sync_q |=> mode_w == 2'h0)
    else $error("Pin low did not select software control.");

  reg_write_a: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    clk_en_in && do_write && aw_addr_q == PDC_CTRL_ONE_OFFS &&
    w_strb_q == 4'hF |=> control_function_reg_one_q == $past(w_data_q))
    else $error("Control register write lost.");

  active_low_a: assert property (
    @(posedge clock_in) disable iff (sys_rst_in)
    clk_en_in && !pin_sync_q && control_function_reg_one_q[7:4] == 4'h0
    |=> !(dig_pd_out || pll_pd_out || dac_pd_out || clk_pd_out))
    else $error("Zero bits did not give active operation.");

endmodule
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the power-down control top.
// Assumes the host pin model and the design package are compiled first.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) \
  begin n_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD %s expected %0h seen %0h", nm, e, g); end end
module tb;
  import pdc_pkg::*;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic clk = 1'b0, rst = 1'b1, cen = 1'b1, lvl = 1'b0, slow = 1'b0, pin;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, ctrl = 32'h0, d;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, dig, pll, dac, ckp;
  logic [1:0] bresp, rresp, r;
  logic [15:0] lf = 16'h001C;
  int bad_count = 0, n_checks = 0, cyc = 0;
  // ==========================================================================
  // Design, host and clock
  // ==========================================================================
  pdc_top i_pdc_top (.clock_in(clk), .sys_rst_in(rst), .clk_en_in(cen),
    .external_powerdown_pin_in(pin), .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
    .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .dig_pd_out(dig), .pll_pd_out(pll), .dac_pd_out(dac),
    .clk_pd_out(ckp));
  pdc_host_pin i_pdc_host_pin (.clock_in(clk), .level_in(lvl),
    .slow_in(slow), .pin_out(pin));
  // The clock runs at 250 MHz.
  initial
  begin
    forever #2 clk = ~clk;
  end
  // A hung handshake is cut short well past the expected run length.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      end_sim();
    end
  end
  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  // Handshakes are judged at the falling edge, which sees what the next
  // rising edge samples, so no race with the design's own updates.
  task automatic wr(input logic [7:0] a, input logic [31:0] dd,
                    input logic [3:0] s, output logic [1:0] rs);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk);
    awaddr <= a; wdata <= dd; wstrb <= s;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(negedge clk);
      if (awvalid && awready) aw_ok = 1'b1;
      if (wvalid && wready) w_ok = 1'b1;
      @(posedge clk);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
    end
    do @(negedge clk); while (bvalid !== 1'b1);
    rs = bresp;
    @(posedge clk) bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] dd,
                    output logic [1:0] rs);
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(negedge clk); while (arready !== 1'b1);
    @(posedge clk) arvalid <= 1'b0;
    do @(negedge clk); while (rvalid !== 1'b1);
    dd = rdata;
    rs = rresp;
    @(posedge clk) rready <= 1'b0;
  endtask
  // Reference decode from pin level and the control word.
  task automatic chk_all(input string t);
    logic [31:0] v;
    logic e_dig, e_dac, e_clk;
    logic [1:0] e_mode;
    e_dig = lvl ? 1'b1 : ctrl[7];
    e_dac = lvl ? ctrl[3] : ctrl[5];
    e_clk = lvl ? ctrl[3] : ctrl[4];
    e_mode = !lvl ? 2'h0 : (ctrl[3] ? 2'h2 : 2'h1);
    `CHK("dig_pd", e_dig, dig)
    `CHK("dac_pd", e_dac, dac)
    `CHK("clk_pd", e_clk, ckp)
    `CHK("pll_pd", ctrl[6], pll)
    rd(PDC_STATUS_OFFS, v, r);
    `CHK("status", {e_dig, ctrl[6], e_dac, e_clk, 1'b0, e_mode, lvl},
         v[7:0])
    rd(PDC_CTRL_ONE_OFFS, v, r);
    `CHK("ctrl", ctrl, v)
    `CHK("rresp", PDC_RESP_OKAY, r)
    $display("test %s done", t);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk_all("reset");
    // Every pin level and depth select, fast and slow host, random bits.
    for (int i = 0; i < 24; i++)
    begin
      lf = lfsr(lf);
      d = {lf, lf ^ 16'h5A3C};
      d[3] = i[1];
      wr(PDC_CTRL_ONE_OFFS, d, 4'hF, r);
      `CHK("bresp", PDC_RESP_OKAY, r)
      ctrl = d;
      lvl <= i[0];
      slow <= i[2];
      repeat (12) @(posedge clk);
      chk_all("decode");
    end
    // Unmapped and read-only places refuse and leave the register alone.
    wr(8'h08, 32'hFFFF_FFFF, 4'hF, r);
    `CHK("bresp_unmapped", PDC_RESP_SLVERR, r)
    wr(PDC_STATUS_OFFS, 32'hFFFF_FFFF, 4'hF, r);
    `CHK("bresp_status", PDC_RESP_SLVERR, r)
    rd(8'h0C, d, r);
    `CHK("rresp_unmapped", PDC_RESP_SLVERR, r)
    `CHK("rdata_unmapped", 32'h0, d)
    // Only the lowest byte lane changes, with the pin released.
    lvl <= 1'b0;
    wr(PDC_CTRL_ONE_OFFS, ~ctrl, 4'h1, r);
    `CHK("bresp_strobe", PDC_RESP_OKAY, r)
    ctrl[7:0] = ~ctrl[7:0];
    repeat (12) @(posedge clk);
    chk_all("strobe");
    // A low clock enable freezes the outputs while the pin rises.
    wr(PDC_CTRL_ONE_OFFS, 32'h0000_0008, 4'hF, r);
    ctrl = 32'h0000_0008;
    repeat (2) @(posedge clk);
    cen <= 1'b0;
    lvl <= 1'b1;
    repeat (12) @(posedge clk);
    `CHK("frozen", 3'h0, {dig, dac, ckp})
    cen <= 1'b1;
    repeat (12) @(posedge clk);
    chk_all("enable");
    // Reset in mid-run clears the register; the pin still decides.
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    ctrl = 32'h0;
    repeat (12) @(posedge clk);
    chk_all("rerun");
    end_sim();
  end
endmodule
`default_nettype wire
